/* File: hw/ovd_pkg.sv */
// Purpose: Constants, carriers and state layout of the overrange detector
// Assumes: One device clock; AHB-Lite register slave, 32-bit data
// Notes:   Register map and field positions are defined here only
//
// Summary of operation
// [R1] Compare upper magnitude byte against two thresholds
// [R2] Both channels share the same threshold pair
// [R3] Magnitude saturates most negative code to maximum
// [R4] Overrange bit set when magnitude reaches threshold
// [R5] Two flag outputs per channel, one per threshold
// [R6] Outside logic ORs channel flags in single-channel
// [R7] Flag held eight times two-to-N cycles after event
// [R8] Embed status in samples for one-control-bit formats
// [R9] Complex: first flag in I, second in Q
// [R10] Real: first flag even samples, second odd
// [R11] Window 2^(N+1) real, 2^N complex samples
// [R12] Gain logic picks high and low threshold levels
// [R13] Thresholds and period programmable, no extra delay
package ovd_pkg;

  // Widths
  localparam int SMP_W = 12;
  localparam int MAG_W = 8;
  localparam int PER_W = 3;
  localparam int FMT_W = 5;
  localparam int DEC_W = 16;
  localparam int NFLAG = 4;
  localparam int CNT_W = 11;
  localparam int WIN_W = 9;
  localparam int ADR_W = 12;

  // Hold time base and window base, in cycles and samples
  localparam logic [CNT_W-1:0] HOLD_BASE = 11'h008;
  localparam logic [WIN_W-1:0] WIN_ONE   = 9'h001;

  // Link format codes with one control bit per sample, except FMT_CPX_SKIP
  localparam logic [FMT_W-1:0] FMT_REAL     = 5'h09;
  localparam logic [FMT_W-1:0] FMT_CPX_LO   = 5'h0a;
  localparam logic [FMT_W-1:0] FMT_CPX_HI   = 5'h10;
  localparam logic [FMT_W-1:0] FMT_CPX_SKIP = 5'h0c;

  // Register byte addresses
  localparam logic [ADR_W-1:0] ADR_CTRL = 12'h000;
  localparam logic [ADR_W-1:0] ADR_STAT = 12'h004;
  localparam logic [ADR_W-1:0] ADR_MASK = 12'h008;
  localparam logic [ADR_W-1:0] ADR_FLAG = 12'h00c;

  // Control register field positions
  localparam int CTL_HI_LSB  = 0;
  localparam int CTL_LO_LSB  = 8;
  localparam int CTL_PER_LSB = 16;
  localparam int CTL_FMT_LSB = 20;

  // Reset values: only full-scale trips, plain output stream
  localparam logic [MAG_W-1:0] THR_RST = 8'hff;
  localparam logic [PER_W-1:0] PER_RST = 3'h0;
  localparam logic [FMT_W-1:0] FMT_RST = 5'h00;

  // AHB-Lite transfer type bit that marks an active transfer
  localparam int HTRANS_ACT = 1;

  // Converted samples of both channels
  typedef struct packed {
    logic [SMP_W-1:0] a;
    logic [SMP_W-1:0] b;
    logic             vld;
  } ovd_smp_s;

  // Decimated samples; q marks a quadrature sample
  typedef struct packed {
    logic [DEC_W-1:0] a;
    logic [DEC_W-1:0] b;
    logic             vld;
    logic             q;
  } ovd_dec_s;

  // Whole state of the block
  typedef struct packed {
    logic [MAG_W-1:0]            thr_hi;
    logic [MAG_W-1:0]            thr_lo;
    logic [PER_W-1:0]            per;
    logic [FMT_W-1:0]            fmt;
    logic [NFLAG-1:0]            stat;
    logic [NFLAG-1:0]            mask;
    logic [NFLAG-1:0][CNT_W-1:0] cnt;
    logic [NFLAG-1:0]            flag;
    logic [NFLAG-1:0]            acc;
    logic [NFLAG-1:0]            emb;
    logic [WIN_W-1:0]            win;
    logic                        odd;
    logic [DEC_W-1:0]            dec_a;
    logic [DEC_W-1:0]            dec_b;
    logic                        dec_vld;
    logic                        irq;
    logic                        dph_wr;
    logic [ADR_W-1:0]            dph_adr;
    logic [31:0]                 rdata;
    logic                        ready;
  } ovd_state_s;

endpackage

/* File: hw/ovd_top.sv */
// Purpose: Overrange detector with flag pins and embedded sample status
// Assumes: Samples come from logic on the same clock, so no synchronisers
// Notes:   Flag index k: bit0 threshold (0 high, 1 low), bit1 channel
`timescale 1ns/10ps
module ovd_top
(
  // Clock and reset
  input  wire logic            I_REF_CLK,
  input  wire logic            I_RST,
  // AHB-Lite slave
  input  wire logic            I_HSEL,
  input  wire logic [31:0]     I_HADDR,
  input  wire logic [1:0]      I_HTRANS,
  input  wire logic            I_HWRITE,
  input  wire logic [2:0]      I_HSIZE,
  input  wire logic [31:0]     I_HWDATA,
  input  wire logic            I_HREADY,
  output logic      [31:0]     O_HRDATA,
  output logic                 O_HREADYOUT,
  output logic                 O_HRESP,
  // Converter samples and decimated stream
  input  wire ovd_pkg::ovd_smp_s I_SMP,
  input  wire ovd_pkg::ovd_dec_s I_DEC,
  output logic [ovd_pkg::DEC_W-1:0] O_DEC_A,
  output logic [ovd_pkg::DEC_W-1:0] O_DEC_B,
  output logic                 O_DEC_VLD,
  // Flag pins and interrupt
  output logic                 O_CHAN_A_FLAG_FIRST,
  output logic                 O_CHAN_A_FLAG_SECOND,
  output logic                 O_CHAN_B_FLAG_FIRST,
  output logic                 O_CHAN_B_FLAG_SECOND,
  output logic                 O_IRQ
);
  import ovd_pkg::*;

  // Absolute value, most negative code saturates, upper byte kept
  function automatic logic [MAG_W-1:0] mag8(input logic [SMP_W-1:0] s);
    logic [SMP_W-1:0] m;
    m = s;
    if (s[SMP_W-1])
    begin
      m = (s == {1'b1, {(SMP_W-1){1'b0}}}) ? {1'b0, {(SMP_W-1){1'b1}}}
                                           : (~s + 1'b1); // R3
    end
    return m[SMP_W-2 -: MAG_W];
  endfunction

  // Hold length: eight times two to the N device clocks
  function automatic logic [CNT_W-1:0] hold_len(input logic [PER_W-1:0] n);
    return HOLD_BASE << n; // R7
  endfunction

  ovd_state_s st;
  ovd_state_s next_st;

  logic [NFLAG-1:0] hit;
  logic             emb_en;
  logic             real_mode;
  logic [WIN_W-1:0] win_len;
  logic             win_end;
  logic             bus_act;
  logic [31:0]      ctrl_word;

  // Threshold hits straight from the live settings, no extra stage
  always_comb
  begin
    hit[0] = I_SMP.vld && (mag8(I_SMP.a) >= st.thr_hi); // R1 R4 R13
    hit[1] = I_SMP.vld && (mag8(I_SMP.a) >= st.thr_lo); // R1 R4 R5
    hit[2] = I_SMP.vld && (mag8(I_SMP.b) >= st.thr_hi); // R2
    hit[3] = I_SMP.vld && (mag8(I_SMP.b) >= st.thr_lo); // R2 R5
  end

  // Embedding only in formats carrying one control bit per sample
  always_comb
  begin
    real_mode = (st.fmt == FMT_REAL);
    emb_en    = real_mode || ((st.fmt >= FMT_CPX_LO) &&
                (st.fmt <= FMT_CPX_HI) && (st.fmt != FMT_CPX_SKIP)); // R8
    win_len   = real_mode ? (WIN_ONE << ({1'b0, st.per} + 4'h1))
                          : (WIN_ONE << st.per); // R11
    win_end   = I_SMP.vld && (st.win == win_len - WIN_ONE);
    bus_act   = I_HSEL && I_HREADY && I_HTRANS[HTRANS_ACT];
    ctrl_word = 32'h0;
    ctrl_word[CTL_HI_LSB  +: MAG_W] = st.thr_hi;
    ctrl_word[CTL_LO_LSB  +: MAG_W] = st.thr_lo;
    ctrl_word[CTL_PER_LSB +: PER_W] = st.per;
    ctrl_word[CTL_FMT_LSB +: FMT_W] = st.fmt;
  end

  // Next state of the whole block
  always_comb
  begin
    logic [NFLAG-1:0] clr;
    logic [DEC_W-1:0] lsb_a;
    logic             sel2;
    lsb_a         = '0;
    sel2          = 1'b0;
    next_st       = st;
    clr           = '0;
    next_st.ready = 1'b1;

    // Data phase of a write; the address phase was latched before
    if (st.dph_wr)
    begin
      case (st.dph_adr)
        ADR_CTRL:
        begin
          next_st.thr_hi = I_HWDATA[CTL_HI_LSB  +: MAG_W]; // R13
          next_st.thr_lo = I_HWDATA[CTL_LO_LSB  +: MAG_W];
          next_st.per    = I_HWDATA[CTL_PER_LSB +: PER_W];
          next_st.fmt    = I_HWDATA[CTL_FMT_LSB +: FMT_W];
        end
        ADR_STAT: clr          = I_HWDATA[NFLAG-1:0];
        ADR_MASK: next_st.mask = I_HWDATA[NFLAG-1:0];
        default:  clr          = '0;
      endcase
    end

    // Address phase: read data is ready for the following data phase
    next_st.dph_wr  = bus_act && I_HWRITE;
    next_st.dph_adr = I_HADDR[ADR_W-1:0];
    next_st.rdata   = 32'h0;
    if (bus_act && !I_HWRITE && (I_HADDR[31:ADR_W] == '0))
    begin
      case (I_HADDR[ADR_W-1:0])
        ADR_CTRL: next_st.rdata = ctrl_word;
        ADR_STAT: next_st.rdata[NFLAG-1:0] = st.stat;
        ADR_MASK: next_st.rdata[NFLAG-1:0] = st.mask;
        ADR_FLAG: next_st.rdata[2*NFLAG-1:0] = {st.emb, st.flag};
        default:  next_st.rdata = 32'h0;
      endcase
    end
    if (I_HADDR[31:ADR_W] != '0)
    begin
      next_st.dph_wr = 1'b0;
    end

    // Sticky events; a hit in the clearing cycle stays set
    next_st.stat = (st.stat & ~clr) | hit;
    next_st.irq  = |(next_st.stat & next_st.mask);

    // Flag pins held for the programmed length after the last hit
    for (int k = 0; k < NFLAG; k++)
    begin
      if (hit[k])
      begin
        next_st.cnt[k]  = hold_len(st.per) - 11'h001; // R7
        next_st.flag[k] = 1'b1; // R4 R5
      end
      else if (st.cnt[k] != '0)
      begin
        next_st.cnt[k]  = st.cnt[k] - 11'h001;
        next_st.flag[k] = 1'b1;
      end
      else
      begin
        next_st.flag[k] = 1'b0;
      end
    end

    // Monitoring window counted in converter samples
    if (I_SMP.vld)
    begin
      next_st.win = win_end ? '0 : (st.win + WIN_ONE); // R11
    end
    if (win_end)
    begin
      next_st.emb = st.acc | hit;
      next_st.acc = '0;
    end
    else
    begin
      next_st.acc = st.acc | hit;
    end

    // A new setting restarts the window, so a shorter period never
    // leaves the counter stranded past its end
    if (st.dph_wr && (st.dph_adr == ADR_CTRL))
    begin
      next_st.win = '0; // R11
      next_st.acc = hit;
    end

    // Embedded status replaces the sample LSB
    next_st.dec_vld = I_DEC.vld;
    if (I_DEC.vld)
    begin
      sel2          = real_mode ? st.odd : I_DEC.q; // R9 R10
      next_st.odd   = ~st.odd;
      next_st.dec_a = I_DEC.a;
      next_st.dec_b = I_DEC.b;
      if (emb_en)
      begin
        lsb_a         = {I_DEC.a[DEC_W-1:1], st.emb[{1'b0, sel2}]};
        next_st.dec_a = lsb_a; // R9 R10
        next_st.dec_b = {I_DEC.b[DEC_W-1:1], st.emb[{1'b1, sel2}]};
      end
    end
  end

  // Single register stage for all state; synchronous reset
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      st        <= '0;
      st.thr_hi <= THR_RST;
      st.thr_lo <= THR_RST;
      st.per    <= PER_RST;
      st.fmt    <= FMT_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops, HRESP tied OKAY; zero-wait once out of reset
  assign O_HRDATA             = st.rdata;
  assign O_HREADYOUT          = st.ready;
  assign O_HRESP              = 1'b0;
  assign O_DEC_A              = st.dec_a;
  assign O_DEC_B              = st.dec_b;
  assign O_DEC_VLD            = st.dec_vld;
  assign O_CHAN_A_FLAG_FIRST  = st.flag[0];
  assign O_CHAN_A_FLAG_SECOND = st.flag[1];
  assign O_CHAN_B_FLAG_FIRST  = st.flag[2];
  assign O_CHAN_B_FLAG_SECOND = st.flag[3];
  assign O_IRQ                = st.irq;

  // Checks on the detector behaviour
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  sat_code_a: assert property (I_SMP.vld && I_SMP.a == 12'h800 // R3
    |=> O_CHAN_A_FLAG_FIRST && O_CHAN_A_FLAG_SECOND)
    else $error("most negative code did not trip both flags");

  thr_hi_a: assert property (I_SMP.vld && mag8(I_SMP.a) >= st.thr_hi // R4
    |=> O_CHAN_A_FLAG_FIRST)
    else $error("channel A first flag missed a hit");

  shared_thr_a: assert property (I_SMP.vld // R2
    && mag8(I_SMP.b) >= st.thr_hi |=> O_CHAN_B_FLAG_FIRST)
    else $error("channel B ignored shared high threshold");

  second_flag_a: assert property (I_SMP.vld // R5
    && mag8(I_SMP.b) >= st.thr_lo |=> O_CHAN_B_FLAG_SECOND)
    else $error("channel B second flag missed a hit");

  hold_min_a: assert property ((hit[0] && st.per == 3'h0) // R7
    |=> O_CHAN_A_FLAG_FIRST [*8])
    else $error("flag released before eight cycles");

  hold_end_a: assert property ((hit[0] && st.per == 3'h0) // R7
    ##1 (!hit[0] && st.per == 3'h0) [*8] |=> !O_CHAN_A_FLAG_FIRST)
    else $error("flag held past eight cycles");

  pass_thru_a: assert property (I_DEC.vld && !emb_en // R8
    |=> O_DEC_A == $past(I_DEC.a) && O_DEC_VLD)
    else $error("sample altered in plain format");

  cpx_q_a: assert property (I_DEC.vld && emb_en && !real_mode // R9
    && I_DEC.q |=> O_DEC_A[0] == $past(st.emb[1])
    && O_DEC_A[DEC_W-1:1] == $past(I_DEC.a[DEC_W-1:1]))
    else $error("Q sample lacks second threshold status");

  real_even_a: assert property (I_DEC.vld && real_mode && emb_en // R10
    && !st.odd |=> O_DEC_B[0] == $past(st.emb[2]))
    else $error("even sample lacks first threshold status");

  win_len_a: assert property (st.win < win_len) // R11
    else $error("monitoring window overran its length");

  irq_lvl_a: assert property (st.dph_wr && st.dph_adr == ADR_MASK
    && (I_HWDATA[NFLAG-1:0] & st.stat) != '0 |=> O_IRQ)
    else $error("unmasking a set status did not raise the interrupt");

  stat_set_a: assert property (|hit
    |=> (st.stat & $past(hit)) == $past(hit))
    else $error("status lost an event in its clearing cycle");

  real_odd_a: assert property (I_DEC.vld && real_mode && emb_en // R10
    && st.odd |=> O_DEC_A[0] == $past(st.emb[1]))
    else $error("odd sample lacks second threshold status");

  cpx_i_a: assert property (I_DEC.vld && emb_en && !real_mode // R9
    && !I_DEC.q |=> O_DEC_B[0] == $past(st.emb[2]))
    else $error("I sample lacks first threshold status");

  plain_b_a: assert property (I_DEC.vld && !emb_en // R8
    |=> O_DEC_B == $past(I_DEC.b))
    else $error("channel B sample altered in plain format");

  flag_drop_a: assert property (!hit[0] && st.cnt[0] == '0 // R7
    |=> !O_CHAN_A_FLAG_FIRST)
    else $error("flag held with its counter expired");

  win_emb_a: assert property (win_end // R11
    |=> st.emb == ($past(st.acc) | $past(hit)))
    else $error("embedded status is not the hits of the window");

  // Main scenarios
  hit_cov_c: cover property (hit[0] ##1 !hit[0] [*8] ##1 !st.flag[0]);
  win_cov_c: cover property (win_end && real_mode);
  emb_cov_c: cover property (O_DEC_VLD && O_DEC_A[0] && emb_en);
  irq_cov_c: cover property ($rose(O_IRQ));
  cpx_cov_c: cover property (O_DEC_VLD && emb_en && !real_mode);

endmodule // ovd_top

/* File: verif/ovd_gain_model.sv */
// Purpose: Downstream gain logic that watches the flag pins
// Assumes: Runs on the detector clock
// Notes:   Merges both channels as single-channel mode needs
`timescale 1ns/10ps
module ovd_gain_model
(
  // Clock, reset and flag pins, index 2*chan+level
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_flag,
  // Merged view and gain request
  output logic            o_first,
  output logic            o_second,
  output logic            o_gain_up
);
  logic [9:0] quiet;
  // Same threshold of both channels merged
  assign o_first  = i_flag[0] | i_flag[2];
  assign o_second = i_flag[1] | i_flag[3];
  // Raise gain only after a long quiet spell, never while clipping;
  // reset keeps unknown flags of the first edge out of the count
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      quiet <= 10'h000;
    end
    else
    begin
      quiet <= o_second ? 10'h000 : quiet + {9'h000, ~&quiet};
    end
  end
  assign o_gain_up = &quiet & ~o_first;
endmodule // ovd_gain_model

/* File: verif/ovd_tb.sv */
// Purpose: Self-checking bench of the overrange detector
// Assumes: Zero-wait bus slave with hready looped back
// Notes:   Each scenario task judges its own results
`timescale 1ns/10ps
module testbench;
  import ovd_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready;
  logic        hresp;
  ovd_smp_s    smp = '0;
  ovd_dec_s    dec = '0;
  logic [15:0] dec_a;
  logic [15:0] dec_b;
  logic        dec_vld;
  logic        irq;
  logic [3:0]  flag;
  logic        m_first;
  logic        m_second;
  logic        m_gain;
  int          num_errors = 0;
  int          comparisons = 0;

  // 40 MHz device clock
  always #12.5 clk = ~clk;

  ovd_top u_dut (
    .I_REF_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_SMP(smp), .I_DEC(dec),
    .O_DEC_A(dec_a), .O_DEC_B(dec_b), .O_DEC_VLD(dec_vld),
    .O_CHAN_A_FLAG_FIRST(flag[0]), .O_CHAN_A_FLAG_SECOND(flag[1]),
    .O_CHAN_B_FLAG_FIRST(flag[2]), .O_CHAN_B_FLAG_SECOND(flag[3]),
    .O_IRQ(irq));

  ovd_gain_model u_gain (.i_clk(clk), .i_rst(rst), .i_flag(flag),
    .o_first(m_first), .o_second(m_second), .o_gain_up(m_gain));

  // Compare and count
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; read data taken at data phase end
  task automatic ahb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // One sample pair taken at the next edge
  task automatic pulse(input logic [11:0] a, input logic [11:0] b);
    @(posedge clk);
    smp <= {a, b, 1'b1};
    @(posedge clk);
    smp.vld <= 1'b0;
    #1;
  endtask

  // One decimated pair of all ones; only the LSB may change
  task automatic dec_one(input logic q, input logic [15:0] ea,
                         input logic [15:0] eb);
    @(posedge clk);
    dec <= {16'hffff, 16'hffff, 1'b1, q};
    @(posedge clk);
    dec.vld <= 1'b0;
    #1 chk({15'h0, dec_vld, dec_a, dec_b}, {16'h1, ea, eb});
  endtask

  // Reset values, read-only flag word, unmapped address
  task automatic t_regs;
    rdc(ADR_CTRL, 32'h0000ffff);
    rdc(ADR_MASK, 32'h0);
    ahb(1'b1, ADR_FLAG, 32'hffffffff);
    rdc(ADR_FLAG, 32'h0);
    rdc(12'h010, 32'h0);
    ahb(1'b1, ADR_CTRL, 32'h0005fe5a);
    rdc(ADR_CTRL, 32'h0005fe5a);
  endtask

  // Equality boundary on both levels, shared thresholds, interrupt
  task automatic t_flags;
    ahb(1'b1, ADR_CTRL, 32'h0000feff);
    pulse(12'h800, 12'h810);
    chk(flag, 4'hb);
    chk({m_second, m_first}, 2'h3);
    rdc(ADR_STAT, 32'hb);
    chk(irq, 1'b0);
    ahb(1'b1, ADR_MASK, 32'h8);
    @(posedge clk);
    #1 chk(irq, 1'b1);
    ahb(1'b1, ADR_STAT, 32'h8);
    @(posedge clk);
    #1 chk(irq, 1'b0);
    rdc(ADR_STAT, 32'h3);
  endtask

  // Stretch for shortest, middle and longest period settings
  task automatic t_hold;
    int ns[3] = '{0, 3, 7};
    foreach (ns[i])
    begin
      ahb(1'b1, ADR_CTRL, {13'h0, ns[i][2:0], 16'hffff});
      pulse(12'h800, 12'h000);
      repeat ((8 << ns[i]) - 1) @(posedge clk);
      #1 chk(flag, 4'h3);
      @(posedge clk);
      #1 chk(flag, 4'h0);
    end
    chk(m_gain, 1'b0);
    repeat (1023) @(posedge clk);
    #1 chk(m_gain, 1'b1);
  endtask

  // Channel A trips the high level only; channel B stays quiet
  task automatic t_embed;
    @(posedge clk);
    smp <= {12'h400, 12'h000, 1'b1};
    ahb(1'b1, ADR_CTRL, 32'h0090ff80);
    repeat (8) @(posedge clk);
    dec_one(1'b0, 16'hffff, 16'hfffe);
    dec_one(1'b0, 16'hfffe, 16'hfffe);
    ahb(1'b1, ADR_CTRL, 32'h00a0ff80);
    dec_one(1'b1, 16'hfffe, 16'hfffe);
    dec_one(1'b0, 16'hffff, 16'hfffe);
    @(posedge clk);
    smp <= {12'h000, 12'h000, 1'b1};
    repeat (8) @(posedge clk);
    dec_one(1'b0, 16'hfffe, 16'hfffe);
    ahb(1'b1, ADR_CTRL, 32'h00c0ff80);
    dec_one(1'b1, 16'hffff, 16'hffff);
    @(posedge clk);
    smp.vld <= 1'b0;
  endtask

  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(hresp, 1'b0);
    t_regs;
    t_flags;
    t_hold;
    t_embed;
    complete_run;
  end

  // Watchdog, well past the longest stretch
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run;
  end
endmodule // testbench
